/* File: logic/brk_evt_pkg.sv */
// constants and types for the on-chip break and event unit
// assumes a single cpu clock domain and a debug reset
package brk_evt_pkg;
  localparam int FETCH_CMP_BIG = 8;
  localparam int OPER_CMP_BIG = 4;
  localparam int COMBO_PTS_BIG = 8;
  localparam int FETCH_CMP_SMALL = 4;
  localparam int OPER_CMP_SMALL = 2;
  localparam int COMBO_PTS_SMALL = 6;
  localparam int ADDR_W = 32;
  localparam int PASS_W = 8;
  localparam int CAUSE_W = 3;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_PRE_EXEC = 3'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_EVENT = 3'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_TRACE_FULL = 3'h3;
  localparam logic [CAUSE_W-1:0] CAUSE_FORCED = 3'h4;
  localparam logic [CAUSE_W-1:0] CAUSE_SW_TRAP = 3'h5;
  typedef enum logic [1:0] {
    COMBO_OR = 2'b00,
    COMBO_AND = 2'b01,
    COMBO_SEQ = 2'b10,
    COMBO_OFF = 2'b11
  } combo_type;
endpackage

/* File: logic/onchip_break_event_unit.sv */
// on-chip break and event unit: address comparators, event combination, halt request
// assumes cpu presents fetch, retire and operand strobes synchronous to sys_clk
`timescale 1ns/1ps
module onchip_break_event_unit #(
  parameter bit LARGE_CFG = 1'b1,
  parameter int NF = LARGE_CFG ? brk_evt_pkg::FETCH_CMP_BIG : brk_evt_pkg::FETCH_CMP_SMALL,
  parameter int NO = LARGE_CFG ? brk_evt_pkg::OPER_CMP_BIG : brk_evt_pkg::OPER_CMP_SMALL,
  parameter int NE = LARGE_CFG ? brk_evt_pkg::COMBO_PTS_BIG : brk_evt_pkg::COMBO_PTS_SMALL
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cpu_halted,
  input wire logic fetch_valid,
  input wire logic [brk_evt_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic retire_valid,
  input wire logic [brk_evt_pkg::ADDR_W-1:0] retire_addr,
  input wire logic oper_valid,
  input wire logic [brk_evt_pkg::ADDR_W-1:0] oper_addr,
  input wire logic sw_trap_exec,
  input wire logic trace_full,
  input wire logic forced_break,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_idx,
  input wire logic [brk_evt_pkg::ADDR_W-1:0] cfg_addr_lo,
  input wire logic [brk_evt_pkg::ADDR_W-1:0] cfg_addr_hi,
  input wire logic cfg_is_fetch,
  input wire logic cfg_is_range,
  input wire logic cfg_pre_exec,
  input wire logic cfg_enable,
  input wire logic [brk_evt_pkg::PASS_W-1:0] cfg_pass_m1,
  input wire logic cfg_pass_en,
  input wire logic combo_we,
  input wire logic [1:0] combo_mode,
  input wire logic [NE-1:0] combo_sel,
  input wire logic [2:0] combo_route,
  input wire logic trace_cfg_we,
  input wire logic trace_full_brk_en,
  input wire logic break_ack,
  output logic halt_req,
  output logic pre_exec_stall,
  output logic [brk_evt_pkg::CAUSE_W-1:0] break_cause,
  output logic trace_trig,
  output logic perf_trig,
  output logic [NE-1:0] event_hit,
  output logic trace_full_en_out
);
  localparam int IW = $clog2(NE);

  logic rst_s1_r, rst_s2_r;
  logic [brk_evt_pkg::ADDR_W-1:0] lo_r [NE];
  logic [brk_evt_pkg::ADDR_W-1:0] hi_r [NE];
  logic [NE-1:0] fetch_r, range_r, pre_r, en_r, pass_en_r;
  logic [brk_evt_pkg::PASS_W-1:0] pass_m1_r [NE];
  logic [brk_evt_pkg::PASS_W:0] pass_cnt_r [NE];
  brk_evt_pkg::combo_type mode_r;
  logic [NE-1:0] sel_r, acc_r;
  logic [2:0] route_r;
  logic [IW:0] seq_pos_r;
  logic tfb_en_r;
  logic [NE-1:0] raw_hit, qual_hit, pre_hit;
  logic combo_fire;
  logic [NE-1:0] acc_nxt;
  logic any_src;

  // reset release through two stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  function automatic logic addr_match(input logic [brk_evt_pkg::ADDR_W-1:0] a,
                                      input logic [brk_evt_pkg::ADDR_W-1:0] lo,
                                      input logic [brk_evt_pkg::ADDR_W-1:0] hi,
                                      input logic rng);
    addr_match = rng ? (a >= lo && a <= hi) : (a == lo);
  endfunction

  function automatic logic slot_ok(input logic [3:0] idx);
    slot_ok = idx < 4'(NE);
  endfunction

  // comparator slots; first NF may watch fetch, first NO may watch operands
  always_comb begin
    for (int i = 0; i < NE; i++) begin
      pre_hit[i] = en_r[i] && pre_r[i] && fetch_r[i] && i < NF && fetch_valid
                   && addr_match(fetch_addr, lo_r[i], hi_r[i], 1'b0);
      if (fetch_r[i]) begin
        raw_hit[i] = en_r[i] && !pre_r[i] && i < NF && retire_valid
                     && addr_match(retire_addr, lo_r[i], hi_r[i], 1'b0);
      end else begin
        raw_hit[i] = en_r[i] && i < NO && oper_valid
                     && addr_match(oper_addr, lo_r[i], hi_r[i], range_r[i]);
      end
    end
  end

  // programming accepted at any time, running or halted
  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      fetch_r <= '0;
      range_r <= '0;
      pre_r <= '0;
      en_r <= '0;
      pass_en_r <= '0;
      for (int i = 0; i < NE; i++) begin
        lo_r[i] <= '0;
        hi_r[i] <= '0;
        pass_m1_r[i] <= '0;
      end
    end else if (cfg_we && slot_ok(cfg_idx)) begin
      lo_r[IW'(cfg_idx)] <= cfg_addr_lo;
      hi_r[IW'(cfg_idx)] <= cfg_addr_hi;
      fetch_r[IW'(cfg_idx)] <= cfg_is_fetch;
      range_r[IW'(cfg_idx)] <= cfg_is_range;
      pre_r[IW'(cfg_idx)] <= cfg_pre_exec;
      en_r[IW'(cfg_idx)] <= cfg_enable;
      pass_en_r[IW'(cfg_idx)] <= cfg_pass_en && LARGE_CFG;
      pass_m1_r[IW'(cfg_idx)] <= cfg_pass_m1;
    end
  end

  // pass counting (LARGE_CFG only): qualify from occurrence number pass_m1+1 on
  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      for (int i = 0; i < NE; i++) pass_cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < NE; i++) begin
        if (cfg_we && cfg_idx == 4'(i)) pass_cnt_r[i] <= '0;
        else if (raw_hit[i] && pass_en_r[i] && pass_cnt_r[i] <= {1'b0, pass_m1_r[i]})
          pass_cnt_r[i] <= pass_cnt_r[i] + 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NE; i++) begin
      qual_hit[i] = raw_hit[i] && (!pass_en_r[i] || pass_cnt_r[i] >= {1'b0, pass_m1_r[i]});
    end
  end

  // combination of selected events
  always_comb begin
    acc_nxt = acc_r | (qual_hit & sel_r);
    combo_fire = 1'b0;
    unique case (mode_r)
      brk_evt_pkg::COMBO_OR: combo_fire = |(qual_hit & sel_r);
      brk_evt_pkg::COMBO_AND: combo_fire = (sel_r != '0) && ((acc_nxt & sel_r) == sel_r);
      brk_evt_pkg::COMBO_SEQ: combo_fire = (sel_r != '0) && seq_pos_r < (IW+1)'(NE)
        && qual_hit[seq_pos_r[IW-1:0]] && ((sel_r >> (seq_pos_r + 1'b1)) == '0);
      brk_evt_pkg::COMBO_OFF: combo_fire = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      mode_r <= brk_evt_pkg::COMBO_OFF;
      sel_r <= '0;
      route_r <= '0;
      acc_r <= '0;
      seq_pos_r <= '0;
    end else if (combo_we) begin
      mode_r <= brk_evt_pkg::combo_type'(combo_mode);
      sel_r <= combo_sel;
      route_r <= combo_route;
      acc_r <= '0;
      seq_pos_r <= '0;
    end else if (combo_fire) begin
      acc_r <= '0;
      seq_pos_r <= '0;
    end else begin
      if (mode_r == brk_evt_pkg::COMBO_AND) acc_r <= acc_nxt;
      // sequence walks selected slots in index order
      if (mode_r == brk_evt_pkg::COMBO_SEQ && seq_pos_r < (IW+1)'(NE)) begin
        if (!sel_r[seq_pos_r[IW-1:0]] || qual_hit[seq_pos_r[IW-1:0]])
          seq_pos_r <= seq_pos_r + 1'b1;
      end
    end
  end

  // trace-full break enable, taken only while halted
  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) tfb_en_r <= 1'b0;
    else if (trace_cfg_we && cpu_halted) tfb_en_r <= trace_full_brk_en;
  end

  assign any_src = |pre_hit || (combo_fire && route_r[0]) || (tfb_en_r && trace_full)
                   || forced_break || sw_trap_exec;

  // halt request and cause
  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      halt_req <= 1'b0;
      break_cause <= brk_evt_pkg::CAUSE_NONE;
      pre_exec_stall <= 1'b0;
    end else begin
      pre_exec_stall <= |pre_hit;
      if (|pre_hit) begin
        halt_req <= 1'b1;
        break_cause <= brk_evt_pkg::CAUSE_PRE_EXEC;
      end else if (combo_fire && route_r[0]) begin
        halt_req <= 1'b1;
        break_cause <= brk_evt_pkg::CAUSE_EVENT;
      end else if (tfb_en_r && trace_full) begin
        halt_req <= 1'b1;
        break_cause <= brk_evt_pkg::CAUSE_TRACE_FULL;
      end else if (forced_break) begin
        halt_req <= 1'b1;
        break_cause <= brk_evt_pkg::CAUSE_FORCED;
      end else if (sw_trap_exec) begin
        halt_req <= 1'b1;
        break_cause <= brk_evt_pkg::CAUSE_SW_TRAP;
      end else if (break_ack) begin
        halt_req <= 1'b0;
      end
    end
  end

  // trigger routing
  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      trace_trig <= 1'b0;
      perf_trig <= 1'b0;
      event_hit <= '0;
      trace_full_en_out <= 1'b0;
    end else begin
      trace_trig <= combo_fire && route_r[1];
      perf_trig <= combo_fire && route_r[2];
      event_hit <= qual_hit;
      trace_full_en_out <= tfb_en_r;
    end
  end

  // checks
  pre_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    |pre_hit |=> halt_req && break_cause == brk_evt_pkg::CAUSE_PRE_EXEC)
    else $error("pre-execution hit did not halt");
  stall_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    pre_exec_stall |-> halt_req && break_cause == brk_evt_pkg::CAUSE_PRE_EXEC)
    else $error("stall without pre-execution halt");
  trace_full_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (tfb_en_r && trace_full && !(|pre_hit) && !(combo_fire && route_r[0])) |=>
    halt_req && break_cause == brk_evt_pkg::CAUSE_TRACE_FULL)
    else $error("trace full did not halt");
  trace_cfg_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    !cpu_halted |=> $stable(tfb_en_r))
    else $error("trace-full setting changed while running");
  tfb_taken_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (trace_cfg_we && cpu_halted) |=> tfb_en_r == $past(trace_full_brk_en))
    else $error("trace-full setting refused while halted");
  forced_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    forced_break |=> halt_req)
    else $error("forced break ignored");
  sw_trap_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (sw_trap_exec && !(|pre_hit) && !(combo_fire && route_r[0]) && !(tfb_en_r && trace_full) && !forced_break)
    |=> halt_req && break_cause == brk_evt_pkg::CAUSE_SW_TRAP)
    else $error("trap instruction did not halt");
  or_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (mode_r == brk_evt_pkg::COMBO_OR && |(qual_hit & sel_r) && route_r[1]) |=> trace_trig)
    else $error("or combination missed");
  or_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (mode_r == brk_evt_pkg::COMBO_OR && (qual_hit & sel_r) == '0) |-> !combo_fire)
    else $error("or combination fired with no event");
  and_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (mode_r == brk_evt_pkg::COMBO_AND && ((acc_r | qual_hit) & sel_r) != sel_r) |-> !combo_fire)
    else $error("and combination fired early");
  seq_order_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (mode_r == brk_evt_pkg::COMBO_SEQ && combo_fire) |-> sel_r[seq_pos_r[IW-1:0]] && qual_hit[seq_pos_r[IW-1:0]])
    else $error("sequence fired out of order");
  event_brk_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (combo_fire && route_r[0] && !(|pre_hit)) |=> halt_req && break_cause == brk_evt_pkg::CAUSE_EVENT)
    else $error("routed event did not halt");
  perf_trig_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    combo_fire && route_r[2] |=> perf_trig)
    else $error("performance trigger missed");
  trig_route_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    !combo_fire |=> !trace_trig && !perf_trig)
    else $error("trigger without combination");
  event_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (qual_hit != '0) |=> event_hit == $past(qual_hit))
    else $error("event hits not reported");
  and_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (combo_fire || combo_we) |=> acc_r == '0)
    else $error("and latches not cleared");
  seq_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (combo_fire || combo_we) |=> seq_pos_r == '0)
    else $error("sequence position not cleared");
  no_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (cfg_we && cfg_pass_en && slot_ok(cfg_idx)) |=> pass_en_r[IW'($past(cfg_idx))] == LARGE_CFG)
    else $error("pass count setting wrong for configuration");
  prog_run_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (cfg_we && slot_ok(cfg_idx) && !cpu_halted) |=> lo_r[IW'($past(cfg_idx))] == $past(cfg_addr_lo))
    else $error("slot write refused while running");
  retire_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    !retire_valid |-> (raw_hit & fetch_r) == '0)
    else $error("fetch event before retire");
  hold_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    halt_req && !break_ack |=> halt_req)
    else $error("halt request dropped");
  ack_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
    (break_ack && !any_src) |=> !halt_req)
    else $error("halt request kept after ack");

  for (genvar g = 0; g < NO; g++) begin : g_oper_chk
    range_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
      (en_r[g] && !fetch_r[g] && range_r[g] && oper_valid && oper_addr >= lo_r[g] && oper_addr <= hi_r[g])
      |-> raw_hit[g])
      else $error("range access missed");
  end

  for (genvar g = 0; g < NF; g++) begin : g_fetch_chk
    retire_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
      (en_r[g] && fetch_r[g] && !pre_r[g] && retire_valid && retire_addr == lo_r[g]) |-> raw_hit[g])
      else $error("retired instruction missed");
  end

  for (genvar g = 0; g < NE; g++) begin : g_pass_chk
    pass_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
      pass_cnt_r[g] <= {1'b0, pass_m1_r[g]} + 1'b1)
      else $error("pass count overran");
    pass_early_a: assert property (@(posedge sys_clk) disable iff (!rst_s2_r)
      (pass_en_r[g] && pass_cnt_r[g] < {1'b0, pass_m1_r[g]}) |-> !qual_hit[g])
      else $error("event qualified before its count");
  end
endmodule

/* File: dv/debug_probe_model.sv */
// debugger probe model: programs slots, combination, trace-full break, forced halt and ack
// assumes cpu_halted comes from the bench; all outputs change at the falling edge
`timescale 1ns/1ps
module debug_probe_model #(
  parameter int NE = 8
) (
  input wire logic sys_clk,
  input wire logic cpu_halted,
  input wire logic trace_full_en_out,
  output logic cfg_we,
  output logic [3:0] cfg_idx,
  output logic [brk_evt_pkg::ADDR_W-1:0] cfg_addr_lo,
  output logic [brk_evt_pkg::ADDR_W-1:0] cfg_addr_hi,
  output logic cfg_is_fetch,
  output logic cfg_is_range,
  output logic cfg_pre_exec,
  output logic cfg_enable,
  output logic [brk_evt_pkg::PASS_W-1:0] cfg_pass_m1,
  output logic cfg_pass_en,
  output logic combo_we,
  output logic [1:0] combo_mode,
  output logic [NE-1:0] combo_sel,
  output logic [2:0] combo_route,
  output logic trace_cfg_we,
  output logic trace_full_brk_en,
  output logic forced_break,
  output logic break_ack
);
  initial begin
    {cfg_we, cfg_idx, cfg_addr_lo, cfg_addr_hi, cfg_pass_m1} = '0;
    {cfg_is_fetch, cfg_is_range, cfg_pre_exec, cfg_enable, cfg_pass_en} = '0;
    {combo_we, combo_mode, combo_sel, combo_route} = '0;
    {trace_cfg_we, trace_full_brk_en, forced_break, break_ack} = '0;
  end
  // f = {fetch, range, pre_exec, enable, pass_en}
  task automatic slot(input logic [3:0] i, input logic [31:0] lo, input logic [31:0] hi,
                      input logic [4:0] f, input logic [7:0] pm1);
    @(negedge sys_clk);
    {cfg_idx, cfg_addr_lo, cfg_addr_hi, cfg_pass_m1} = {i, lo, hi, pm1};
    {cfg_is_fetch, cfg_is_range, cfg_pre_exec, cfg_enable, cfg_pass_en} = f;
    cfg_we = 1'b1;
    @(negedge sys_clk);
    cfg_we = 1'b0;
  endtask
  task automatic combo(input logic [1:0] m, input logic [NE-1:0] s, input logic [2:0] r);
    @(negedge sys_clk);
    {combo_mode, combo_sel, combo_route} = {m, s, r};
    combo_we = 1'b1;
    @(negedge sys_clk);
    combo_we = 1'b0;
  endtask
  // rogue set only where a scenario asks for a write while running
  task automatic trace_cfg(input logic en, input bit rogue);
    @(negedge sys_clk);
    if (cpu_halted || rogue) begin
      trace_full_brk_en = en;
      trace_cfg_we = 1'b1;
    end
    @(negedge sys_clk);
    trace_cfg_we = 1'b0;
  endtask
  // each read samples the live pin, never a kept copy
  task automatic read_tfb(output logic v);
    @(negedge sys_clk);
    v = trace_full_en_out;
  endtask
  task automatic pulse_ack(input bit force_it);
    @(negedge sys_clk);
    if (force_it) forced_break = 1'b1;
    else break_ack = 1'b1;
    @(negedge sys_clk);
    {forced_break, break_ack} = 2'b00;
  endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the break and event unit
// assumes the probe model programs the unit; cpu strobes come from here
`timescale 1ns/1ps
module tb;
  localparam int NE = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_halted, fetch_valid, retire_valid, oper_valid, sw_trap_exec, trace_full;
  logic [31:0] fetch_addr, retire_addr, oper_addr;
  wire logic cfg_we, cfg_is_fetch, cfg_is_range, cfg_pre_exec, cfg_enable, cfg_pass_en;
  wire logic combo_we, trace_cfg_we, trace_full_brk_en, forced_break, break_ack;
  wire logic [3:0] cfg_idx;
  wire logic [31:0] cfg_addr_lo, cfg_addr_hi;
  wire logic [7:0] cfg_pass_m1;
  wire logic [1:0] combo_mode;
  wire logic [NE-1:0] combo_sel, event_hit;
  wire logic [2:0] combo_route, break_cause;
  wire logic halt_req, pre_exec_stall, trace_trig, perf_trig, trace_full_en_out;
  logic tfb_rd;
  int mismatches = 0;
  int cmp_count = 0;
  always #50 sys_clk = ~sys_clk;
  onchip_break_event_unit u_onchip_break_event_unit (.sys_clk, .rst_n, .cpu_halted, .fetch_valid,
    .fetch_addr, .retire_valid, .retire_addr, .oper_valid, .oper_addr, .sw_trap_exec, .trace_full,
    .forced_break, .cfg_we, .cfg_idx, .cfg_addr_lo, .cfg_addr_hi, .cfg_is_fetch, .cfg_is_range,
    .cfg_pre_exec, .cfg_enable, .cfg_pass_m1, .cfg_pass_en, .combo_we, .combo_mode, .combo_sel,
    .combo_route, .trace_cfg_we, .trace_full_brk_en, .break_ack, .halt_req, .pre_exec_stall,
    .break_cause, .trace_trig, .perf_trig, .event_hit, .trace_full_en_out);
  debug_probe_model u_debug_probe_model (.sys_clk, .cpu_halted, .trace_full_en_out, .cfg_we, .cfg_idx, .cfg_addr_lo,
    .cfg_addr_hi, .cfg_is_fetch, .cfg_is_range, .cfg_pre_exec, .cfg_enable, .cfg_pass_m1,
    .cfg_pass_en, .combo_we, .combo_mode, .combo_sel, .combo_route, .trace_cfg_we,
    .trace_full_brk_en, .forced_break, .break_ack);
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t flag got %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_cause(input logic [2:0] exp);
    cmp_count++;
    if (break_cause !== exp) begin
      mismatches++;
      $display("ERROR %0t cause got %h want %h", $time, break_cause, exp);
    end
  endtask
  task automatic chk_hits(input logic [NE-1:0] exp);
    cmp_count++;
    if (event_hit !== exp) begin
      mismatches++;
      $display("ERROR %0t hits got %h want %h", $time, event_hit, exp);
    end
  endtask
  // k: 0 fetch, 1 retire, 2 operand
  task automatic cpu(input int k, input logic [31:0] a);
    @(negedge sys_clk);
    {fetch_addr, retire_addr, oper_addr} = {a, a, a};
    {fetch_valid, retire_valid, oper_valid} = {k == 0, k == 1, k == 2};
    @(negedge sys_clk);
    {fetch_valid, retire_valid, oper_valid} = 3'b000;
  endtask
  // waits a bounded span for the halt, then checks its cause
  task automatic wait_halt(input logic [2:0] c);
    for (int n = 0; n < 4 && halt_req !== 1'b1; n++) @(negedge sys_clk);
    chk(halt_req, 1'b1);
    chk_cause(c);
  endtask
  task automatic release_halt();
    u_debug_probe_model.pulse_ack(1'b0);
    @(negedge sys_clk);
    chk(halt_req, 1'b0);
  endtask
  task automatic no_halt();
    repeat (4) @(negedge sys_clk);
    chk(halt_req, 1'b0);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {cpu_halted, fetch_valid, retire_valid, oper_valid, sw_trap_exec, trace_full} = '0;
    {fetch_addr, retire_addr, oper_addr} = '0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    u_debug_probe_model.slot(4'h0, 32'h100, 32'h100, 5'b10110, 8'h00);
    cpu(0, 32'h100);
    wait_halt(brk_evt_pkg::CAUSE_PRE_EXEC);
    chk(pre_exec_stall, 1'b1);
    release_halt();
    u_debug_probe_model.slot(4'h0, 32'h100, 32'h100, 5'b10100, 8'h00);
    $display("test pre_exec done");
    u_debug_probe_model.slot(4'h1, 32'h200, 32'h20f, 5'b01010, 8'h00);
    u_debug_probe_model.combo(2'b00, 8'h02, 3'b111);
    cpu(2, 32'h208);
    wait_halt(brk_evt_pkg::CAUSE_EVENT);
    chk(trace_trig, 1'b1);
    chk(perf_trig, 1'b1);
    chk_hits(8'h02);
    release_halt();
    $display("test or_range done");
    u_debug_probe_model.slot(4'h2, 32'h300, 32'h300, 5'b10010, 8'h00);
    u_debug_probe_model.combo(2'b01, 8'h06, 3'b001);
    cpu(2, 32'h208);
    cpu(0, 32'h300);
    no_halt();
    cpu(1, 32'h300);
    wait_halt(brk_evt_pkg::CAUSE_EVENT);
    release_halt();
    $display("test and done");
    u_debug_probe_model.combo(2'b10, 8'h06, 3'b001);
    cpu(1, 32'h300);
    cpu(2, 32'h208);
    no_halt();
    cpu(1, 32'h300);
    wait_halt(brk_evt_pkg::CAUSE_EVENT);
    release_halt();
    $display("test sequence done");
    u_debug_probe_model.slot(4'h3, 32'h400, 32'h400, 5'b00011, 8'h02);
    u_debug_probe_model.combo(2'b00, 8'h08, 3'b001);
    cpu(2, 32'h400);
    cpu(2, 32'h400);
    no_halt();
    cpu(2, 32'h400);
    wait_halt(brk_evt_pkg::CAUSE_EVENT);
    release_halt();
    u_debug_probe_model.combo(2'b11, 8'h00, 3'b000);
    $display("test pass_count done");
    u_debug_probe_model.trace_cfg(1'b1, 1'b1);
    u_debug_probe_model.read_tfb(tfb_rd);
    chk(tfb_rd, 1'b0);
    cpu_halted = 1'b1;
    u_debug_probe_model.trace_cfg(1'b1, 1'b0);
    u_debug_probe_model.read_tfb(tfb_rd);
    chk(tfb_rd, 1'b1);
    cpu_halted = 1'b0;
    trace_full = 1'b1;
    wait_halt(brk_evt_pkg::CAUSE_TRACE_FULL);
    trace_full = 1'b0;
    release_halt();
    $display("test trace_full done");
    sw_trap_exec = 1'b1;
    u_debug_probe_model.pulse_ack(1'b1);
    sw_trap_exec = 1'b0;
    wait_halt(brk_evt_pkg::CAUSE_FORCED);
    release_halt();
    sw_trap_exec = 1'b1;
    @(negedge sys_clk);
    sw_trap_exec = 1'b0;
    wait_halt(brk_evt_pkg::CAUSE_SW_TRAP);
    release_halt();
    $display("test forced_trap done");
    results();
  end
  initial begin
    #(5000 * 100);
    mismatches++;
    results();
  end
endmodule
